// ==== pkg/scsi_host_defs.svh ====
// Purpose: constants of the control and event queue engine
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   byte addresses, field positions, codes and counts
`ifndef SCSI_HOST_DEFS_SVH
`define SCSI_HOST_DEFS_SVH

// --------------------------------------------------------------
// register byte addresses
// --------------------------------------------------------------
`define A_CTL_TYPE     8'h00
`define A_CTL_SUBTYPE  8'h04
`define A_CTL_LUN_LO   8'h08
`define A_CTL_LUN_HI   8'h0c
`define A_CTL_TAG_LO   8'h10
`define A_CTL_TAG_HI   8'h14
`define A_CTL_EVT_REQ  8'h18
`define A_CTL_SUBMIT   8'h1c
`define A_CTL_RESP     8'h20
`define A_CTL_EVT_ACT  8'h24
`define A_FEATURES     8'h28
`define A_EVQ_POST     8'h2c
`define A_EVQ_WORD     8'h30
`define A_EVQ_LUN_LO   8'h34
`define A_EVQ_LUN_HI   8'h38
`define A_EVQ_REASON   8'h3c
`define A_EVQ_STATUS   8'h40
`define A_SENSE        8'h44

// --------------------------------------------------------------
// request types, subtypes, responses
// --------------------------------------------------------------
`define T_TMF          32'h0000_0000
`define T_AN_QUERY     32'h0000_0001
`define T_AN_SUBSCRIBE 32'h0000_0002
`define TMF_ABORT_TASK 32'h0000_0000
`define TMF_ABORT_SET  32'h0000_0001
`define TMF_CLEAR_ACA  32'h0000_0002
`define TMF_CLEAR_SET  32'h0000_0003
`define TMF_NEXUS_RST  32'h0000_0004
`define TMF_UNIT_RST   32'h0000_0005
`define TMF_QUERY_TASK 32'h0000_0006
`define TMF_QUERY_SET  32'h0000_0007
`define RESP_OK        8'h00
`define RESP_BAD_TGT   8'h03
`define RESP_BUSY      8'h05
`define RESP_XPORT     8'h06
`define RESP_TGT_FAIL  8'h07
`define RESP_NEXUS     8'h08
`define RESP_FAILURE   8'h09
`define RESP_WRONG_UNIT 8'h0c
`define RESP_FN_DONE   8'h00
`define RESP_FN_OK     8'h0a
`define RESP_FN_REJ    8'h0b

// --------------------------------------------------------------
// event masks, event words, reasons, sense
// --------------------------------------------------------------
`define EV_OPER_CHANGE 32'h0000_0002
`define EV_POWER_MGMT  32'h0000_0004
`define EV_EXT_REQ     32'h0000_0008
`define EV_MEDIA       32'h0000_0010
`define EV_MULTI_HOST  32'h0000_0020
`define EV_DEV_BUSY    32'h0000_0040
`define EV_SUPPORTED   32'h0000_0054
`define EVW_NONE       32'h0000_0000
`define EVW_XPORT_RST  32'h0000_0001
`define EVW_ASYNC      32'h0000_0002
`define EVW_LOST_BIT   31
`define RSN_REMOVED    2'h0
`define RSN_HARD       2'h1
`define RSN_RESCAN     2'h2
`define SK_ILLEGAL     4'h5
`define SK_ATTENTION   4'h6
`define ASC_REMOVED    8'h25
`define ASCQ_REMOVED   8'h00
`define ASC_HARD       8'h29
`define ASCQ_HARD      8'h00
`define ASC_RESCAN     8'h3f
`define ASCQ_RESCAN    8'h0e

// --------------------------------------------------------------
// unit address layout and sizes
// --------------------------------------------------------------
`define LUN_FMT_BYTE0  8'h01
`define NUM_TARGETS    8'h04
`define NUM_LUNS       16'h0008
`define HOT_PLUG_BIT   1
`define EVT_INFO_SIZE  32'h0000_0010
`define EVQ_MAX_BUFS   4'hf
`define TAG_SLOTS      4

`endif

// ==== pkg/scsi_host_pkg.sv ====
// Purpose: types shared by the control and event queue engine
// Assumes: constants live in scsi_host_defs.svh
// Notes:   one-hot state codes written out
package scsi_host_pkg;
  typedef enum logic [2:0] {
    ctl_idle   = 3'b001,
    ctl_exec   = 3'b010,
    ctl_commit = 3'b100
  } ctl_state_e;

  typedef logic [63:0] unit_addr_t;
endpackage

// ==== hdl/scsi_host_queues.sv ====
// Purpose: control request engine and event buffer filler on apb
// Assumes: pclk 10 MHz, presetn async active low
// Notes:   one event record slot; driver pops it before the next fill
//
// What this block does
// [R1] control answers use common one-byte response codes
// [R2] tmf is type 0, subtypes 0 to 7
// [R3] driver writes type, subtype, unit, tag fields
// [R4] fields irrelevant to the function are ignored
// [R5] nexus reset ignores the single-level unit part
// [R6] tag compared with tags of queued commands
// [R7] tmf outcomes complete 0, succeeded 10, rejected 11
// [R8] query returns supported subset of requested mask
// [R9] event mask bits 2,4,8,16,32,64
// [R10] subscribe arms unit, returns supported subset
// [R11] query and subscribe use only common codes
// [R12] no buffer posted: event dropped, not held
// [R13] driver keeps 10-15 adequately sized buffers posted
// [R14] lost events set bit 31 of event word
// [R15] short buffer consumed at once with null event
// [R16] after losses, null event with lost bit
// [R17] reset event carries code, unit and reason
// [R18] removed and rescan only with hot plug
// [R19] removed or rescan on unit 0 covers target
// [R20] reset reasons also shown as sense data
// [R21] async notice limited to subscribed events
// [R22] driver polls units itself after losses
// [R23] unit address byte0 1, target, lun, zeros
// [R24] hot plug governed by feature bit 1
// [R25] done set only after all fields written
`timescale 1ns/10ps
`include "scsi_host_defs.svh"
`default_nettype none

module scsi_host_queues
  import scsi_host_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmd_start,
  input  wire logic [63:0] cmd_start_tag,
  input  wire logic [63:0] cmd_start_unit,
  input  wire logic        cmd_end,
  input  wire logic [63:0] cmd_end_tag,
  input  wire logic        reset_evt,
  input  wire logic [1:0]  reset_evt_reason,
  input  wire logic [63:0] reset_evt_unit,
  input  wire logic        notice_evt,
  input  wire logic [63:0] notice_evt_unit,
  input  wire logic [31:0] notice_evt_mask,
  output logic             task_abort,
  output logic      [63:0] task_abort_tag,
  output logic             unit_reset,
  output logic      [63:0] unit_reset_addr,
  output logic             ctl_done,
  output logic             evq_filled
);

  // ------------------------------------------------------------
  // apb slave: one wait state, write lands on the pready edge
  // ------------------------------------------------------------
  logic        access;
  logic        wr_fire;
  logic        mapped;
  logic        refuse;
  logic [31:0] rd_word;

  ctl_state_e  state;
  unit_addr_t  ctl_unit;
  logic [31:0] ctl_type;
  logic [31:0] ctl_subtype;
  logic [63:0] ctl_tag;
  logic [31:0] ctl_evt_req;
  logic [7:0]  ctl_resp;
  logic [31:0] ctl_evt_act;
  logic [31:0] features;

  unit_addr_t  sub_unit;
  logic [31:0] sub_mask;
  logic        sub_valid;

  logic [3:0]  evq_count;
  logic        slot_full;
  logic        lost;
  logic [31:0] slot_word;
  unit_addr_t  slot_unit;
  logic [31:0] slot_reason;
  logic [3:0]  sense_key;
  logic [7:0]  sense_asc;
  logic [7:0]  sense_ascq;

  logic [63:0] tag_tab [`TAG_SLOTS];
  unit_addr_t  unit_tab [`TAG_SLOTS];
  logic [`TAG_SLOTS-1:0] tab_vld;

  assign access  = psel & penable & ~pready;
  assign wr_fire = psel & penable & pready & pwrite & ~pslverr;

  always_comb begin
    mapped  = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      `A_CTL_TYPE:    rd_word = ctl_type;
      `A_CTL_SUBTYPE: rd_word = ctl_subtype;
      `A_CTL_LUN_LO:  rd_word = ctl_unit[31:0];
      `A_CTL_LUN_HI:  rd_word = ctl_unit[63:32];
      `A_CTL_TAG_LO:  rd_word = ctl_tag[31:0];
      `A_CTL_TAG_HI:  rd_word = ctl_tag[63:32];
      `A_CTL_EVT_REQ: rd_word = ctl_evt_req;
      `A_CTL_SUBMIT:  rd_word = {30'h0000_0000, ctl_done, state != ctl_idle};
      `A_CTL_RESP:    rd_word = {24'h00_0000, ctl_resp};
      `A_CTL_EVT_ACT: rd_word = ctl_evt_act;
      `A_FEATURES:    rd_word = features;
      `A_EVQ_POST:    rd_word = {28'h000_0000, evq_count};
      `A_EVQ_WORD:    rd_word = slot_word;
      `A_EVQ_LUN_LO:  rd_word = slot_unit[31:0];
      `A_EVQ_LUN_HI:  rd_word = slot_unit[63:32];
      `A_EVQ_REASON:  rd_word = slot_reason;
      `A_EVQ_STATUS:  rd_word = {30'h0000_0000, lost, slot_full};
      `A_SENSE:       rd_word = {12'h000, sense_key, sense_asc, sense_ascq};
      default:        mapped  = 1'b0;
    endcase
  end

  // full post counter or a short buffer while the slot is busy
  always_comb begin
    refuse = 1'b0;
    if (pwrite && paddr == `A_EVQ_POST) begin
      if (pwdata < `EVT_INFO_SIZE)
        refuse = slot_full;
      else
        refuse = (evq_count == `EVQ_MAX_BUFS);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access & (~mapped | refuse);
      if (access)
        prdata <= (pwrite || !mapped) ? 32'h0000_0000 : rd_word;
    end
  end

  // ------------------------------------------------------------
  // control request fields and feature word
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_type    <= 32'h0000_0000;
      ctl_subtype <= 32'h0000_0000;
      ctl_unit    <= 64'h0000_0000_0000_0000;
      ctl_tag     <= 64'h0000_0000_0000_0000;
      ctl_evt_req <= 32'h0000_0000;
      features    <= 32'h0000_0000;
    end else if (wr_fire) begin
      if (paddr == `A_FEATURES)
        features <= pwdata;
      if (state == ctl_idle) begin  // [R3]
        unique case (paddr)
          `A_CTL_TYPE:    ctl_type          <= pwdata;
          `A_CTL_SUBTYPE: ctl_subtype       <= pwdata;
          `A_CTL_LUN_LO:  ctl_unit[31:0]    <= pwdata;
          `A_CTL_LUN_HI:  ctl_unit[63:32]   <= pwdata;
          `A_CTL_TAG_LO:  ctl_tag[31:0]     <= pwdata;
          `A_CTL_TAG_HI:  ctl_tag[63:32]    <= pwdata;
          `A_CTL_EVT_REQ: ctl_evt_req       <= pwdata;
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // in-flight command tags and the matches against them
  // ------------------------------------------------------------
  logic [`TAG_SLOTS-1:0] tag_hit;
  logic [`TAG_SLOTS-1:0] unit_hit;
  logic [`TAG_SLOTS-1:0] tgt_hit;
  logic [`TAG_SLOTS-1:0] clr_mask;
  logic [`TAG_SLOTS-1:0] free_first;

  always_comb begin
    free_first = '0;
    for (int i = `TAG_SLOTS - 1; i >= 0; i--) begin
      tag_hit[i]  = tab_vld[i] && tag_tab[i] == ctl_tag
                    && unit_tab[i] == ctl_unit;  // [R6]
      unit_hit[i] = tab_vld[i] && unit_tab[i] == ctl_unit;
      tgt_hit[i]  = tab_vld[i] && unit_tab[i][15:8] == ctl_unit[15:8];  // [R5]
    end
    for (int i = `TAG_SLOTS - 1; i >= 0; i--) begin
      if (!tab_vld[i]) begin
        free_first    = '0;
        free_first[i] = 1'b1;
      end
    end
  end

  // a full table silently forgets the new tag; abort then finds nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tab_vld <= '0;
      for (int i = 0; i < `TAG_SLOTS; i++) begin
        tag_tab[i]  <= 64'h0000_0000_0000_0000;
        unit_tab[i] <= 64'h0000_0000_0000_0000;
      end
    end else begin
      for (int i = 0; i < `TAG_SLOTS; i++) begin
        if (state == ctl_exec && clr_mask[i])
          tab_vld[i] <= 1'b0;
        else if (cmd_end && tab_vld[i] && tag_tab[i] == cmd_end_tag)
          tab_vld[i] <= 1'b0;
        else if (cmd_start && free_first[i]) begin
          tab_vld[i]  <= 1'b1;
          tag_tab[i]  <= cmd_start_tag;
          unit_tab[i] <= cmd_start_unit;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // control request decode
  // ------------------------------------------------------------
  logic        fmt_ok;
  logic        lun_ok;
  logic [7:0]  next_resp;
  logic [31:0] next_act;
  logic        next_abort;
  logic        next_unit_rst;
  logic        next_sub;

  assign fmt_ok = ctl_unit[7:0] == `LUN_FMT_BYTE0 && ctl_unit[63:32] == 32'h0000_0000
                  && ctl_unit[15:8] < `NUM_TARGETS;  // [R23]
  assign lun_ok = ctl_unit[31:16] < `NUM_LUNS;

  always_comb begin
    next_resp     = `RESP_FAILURE;  // [R1]
    next_act      = 32'h0000_0000;
    next_abort    = 1'b0;
    next_unit_rst = 1'b0;
    next_sub      = 1'b0;
    clr_mask      = '0;
    if (ctl_type == `T_TMF) begin  // [R2]
      if (!fmt_ok)
        next_resp = `RESP_BAD_TGT;
      else if (ctl_subtype == `TMF_NEXUS_RST) begin
        next_resp = `RESP_FN_DONE;  // [R5]
        clr_mask  = tgt_hit;
      end else if (!lun_ok && ctl_subtype <= `TMF_QUERY_SET)
        next_resp = `RESP_WRONG_UNIT;
      else begin
        unique case (ctl_subtype)  // [R4]
          `TMF_ABORT_TASK: begin
            next_resp  = `RESP_FN_DONE;  // [R7]
            next_abort = |tag_hit;
            clr_mask   = tag_hit;
          end
          `TMF_ABORT_SET, `TMF_CLEAR_SET: begin
            next_resp = `RESP_FN_DONE;
            clr_mask  = unit_hit;
          end
          `TMF_CLEAR_ACA:  next_resp = `RESP_FN_REJ;  // [R7]
          `TMF_UNIT_RST: begin
            next_resp     = `RESP_FN_DONE;
            next_unit_rst = 1'b1;
            clr_mask      = unit_hit;
          end
          `TMF_QUERY_TASK: next_resp = |tag_hit ? `RESP_FN_OK : `RESP_FN_DONE;  // [R6]
          `TMF_QUERY_SET:  next_resp = |unit_hit ? `RESP_FN_OK : `RESP_FN_DONE;
          default:         next_resp = `RESP_FAILURE;
        endcase
      end
    end else if (ctl_type == `T_AN_QUERY || ctl_type == `T_AN_SUBSCRIBE) begin
      if (!fmt_ok)
        next_resp = `RESP_BAD_TGT;  // [R11]
      else if (!lun_ok)
        next_resp = `RESP_WRONG_UNIT;
      else begin
        next_resp = `RESP_OK;
        next_act  = ctl_evt_req & `EV_SUPPORTED;  // [R8] [R9] [R10]
        next_sub  = ctl_type == `T_AN_SUBSCRIBE;
      end
    end
  end

  // ------------------------------------------------------------
  // control request sequence
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state           <= ctl_idle;
      ctl_resp        <= 8'h00;
      ctl_evt_act     <= 32'h0000_0000;
      ctl_done        <= 1'b0;
      task_abort      <= 1'b0;
      task_abort_tag  <= 64'h0000_0000_0000_0000;
      unit_reset      <= 1'b0;
      unit_reset_addr <= 64'h0000_0000_0000_0000;
    end else begin
      task_abort <= 1'b0;
      unit_reset <= 1'b0;
      unique case (state)
        ctl_idle: begin
          if (wr_fire && paddr == `A_CTL_SUBMIT) begin
            state    <= ctl_exec;
            ctl_done <= 1'b0;
          end
        end
        ctl_exec: begin
          ctl_resp    <= next_resp;
          ctl_evt_act <= next_act;
          task_abort  <= next_abort;
          unit_reset  <= next_unit_rst;
          if (next_abort)
            task_abort_tag <= ctl_tag;
          if (next_unit_rst)
            unit_reset_addr <= ctl_unit;
          state <= ctl_commit;
        end
        ctl_commit: begin
          ctl_done <= 1'b1;  // [R25]
          state    <= ctl_idle;
        end
      endcase
    end
  end

  // subscription of one unit at a time; a new one replaces the old
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_unit  <= 64'h0000_0000_0000_0000;
      sub_mask  <= 32'h0000_0000;
      sub_valid <= 1'b0;
    end else if (state == ctl_exec && next_sub) begin
      sub_unit  <= ctl_unit;  // [R10]
      sub_mask  <= next_act;
      sub_valid <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // event queue filler
  // ------------------------------------------------------------
  logic        hot_plug;
  logic        rst_ok;
  logic [31:0] notice_mask;
  logic        notice_ok;
  logic        short_post;
  logic        long_post;
  logic        pop;
  logic        can_fill;
  logic        put_rst;
  logic        put_notice;
  logic        put_null;
  logic        dropped;

  assign hot_plug    = features[`HOT_PLUG_BIT];  // [R24]
  assign rst_ok      = reset_evt && (reset_evt_reason == `RSN_HARD
                       || (hot_plug && reset_evt_reason != 2'h3));  // [R18]
  assign notice_mask = notice_evt_mask & sub_mask;
  assign notice_ok   = notice_evt && sub_valid && notice_evt_unit == sub_unit
                       && notice_mask != 32'h0000_0000;  // [R21]
  assign short_post  = wr_fire && paddr == `A_EVQ_POST && pwdata < `EVT_INFO_SIZE;
  assign long_post   = wr_fire && paddr == `A_EVQ_POST && pwdata >= `EVT_INFO_SIZE;
  assign pop         = wr_fire && paddr == `A_EVQ_STATUS && pwdata[0];
  assign can_fill    = !slot_full && evq_count != 4'h0 && !short_post;
  assign put_rst     = can_fill && rst_ok;
  assign put_notice  = can_fill && !rst_ok && notice_ok;
  assign put_null    = can_fill && !rst_ok && !notice_ok && lost;  // [R16]
  // a notice that loses to a same-cycle reset is counted as lost
  assign dropped     = (rst_ok && !put_rst) || (notice_ok && !put_notice);  // [R12]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evq_count <= 4'h0;
    end else begin
      if (long_post && !(put_rst || put_notice || put_null))
        evq_count <= evq_count + 4'h1;
      else if (!long_post && (put_rst || put_notice || put_null))
        evq_count <= evq_count - 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_full   <= 1'b0;
      slot_word   <= 32'h0000_0000;
      slot_unit   <= 64'h0000_0000_0000_0000;
      slot_reason <= 32'h0000_0000;
      evq_filled  <= 1'b0;
    end else begin
      evq_filled <= 1'b0;
      if (short_post) begin
        slot_full   <= 1'b1;
        evq_filled  <= 1'b1;
        slot_word   <= {lost, 31'h0000_0000} | `EVW_NONE;  // [R15]
        slot_unit   <= 64'h0000_0000_0000_0000;
        slot_reason <= 32'h0000_0000;
      end else if (put_rst) begin
        slot_full   <= 1'b1;
        evq_filled  <= 1'b1;
        slot_word   <= {lost, 31'h0000_0000} | `EVW_XPORT_RST;  // [R14] [R17]
        slot_unit   <= reset_evt_unit;  // [R19]
        slot_reason <= {30'h0000_0000, reset_evt_reason};
      end else if (put_notice) begin
        slot_full   <= 1'b1;
        evq_filled  <= 1'b1;
        slot_word   <= {lost, 31'h0000_0000} | `EVW_ASYNC;  // [R14]
        slot_unit   <= notice_evt_unit;
        slot_reason <= notice_mask;  // [R21]
      end else if (put_null) begin
        slot_full   <= 1'b1;
        evq_filled  <= 1'b1;
        slot_word   <= 32'h8000_0000 | `EVW_NONE;  // [R16]
        slot_unit   <= 64'h0000_0000_0000_0000;
        slot_reason <= 32'h0000_0000;
      end else if (pop) begin
        slot_full <= 1'b0;
      end
    end
  end

  // a drop in the same cycle as a report keeps the flag set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      lost <= 1'b0;
    else if (dropped)
      lost <= 1'b1;  // [R12]
    else if (short_post || put_rst || put_notice || put_null)
      lost <= 1'b0;
  end

  // ------------------------------------------------------------
  // sense view of the last reset condition
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_key  <= 4'h0;
      sense_asc  <= 8'h00;
      sense_ascq <= 8'h00;
    end else if (rst_ok) begin
      unique case (reset_evt_reason)  // [R20]
        `RSN_REMOVED: begin
          sense_key  <= `SK_ILLEGAL;
          sense_asc  <= `ASC_REMOVED;
          sense_ascq <= `ASCQ_REMOVED;
        end
        `RSN_HARD: begin
          sense_key  <= `SK_ATTENTION;
          sense_asc  <= `ASC_HARD;
          sense_ascq <= `ASCQ_HARD;
        end
        default: begin
          sense_key  <= `SK_ATTENTION;
          sense_asc  <= `ASC_RESCAN;
          sense_ascq <= `ASCQ_RESCAN;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== test/scsi_host_queues_props.sv ====
// Purpose: port checker for the queue engine
// Assumes: apb slave with one wait state
// Notes:   bound below the module
`timescale 1ns/10ps
`include "scsi_host_defs.svh"
`default_nettype none
module scsi_host_queues_props (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       reset_evt,
  input wire logic       notice_evt,
  input wire logic       task_abort,
  input wire logic       unit_reset,
  input wire logic       ctl_done,
  input wire logic       evq_filled
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       take;
  logic       sub;
  logic [1:0] wr_d;
  assign take = psel & penable & pready & pwrite;
  assign sub  = take && paddr == `A_CTL_SUBMIT;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_d <= 2'h0;
    else wr_d <= {wr_d[0], take && (paddr == `A_EVQ_POST || paddr == `A_EVQ_STATUS)};
  end
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("pready too long");
  AST_WAIT_STATE: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("wait state wrong");
  AST_ERR_QUAL: assert property (pslverr |-> pready) else $error("pslverr alone");
  AST_UNMAPPED: assert property (psel && penable && pready && paddr > 8'h44 |-> pslverr)
    else $error("unmapped not refused");
  AST_DONE_TIME: assert property (sub |=> !ctl_done [*2] ##1 ctl_done)
    else $error("done timing");
  AST_ABORT_PULSE: assert property (task_abort |=> !task_abort) else $error("abort long");
  AST_ABORT_CAUSE: assert property (task_abort |-> $past(sub, 2))
    else $error("stray abort");
  AST_URST_CAUSE: assert property (unit_reset |-> $past(sub, 2))
    else $error("stray unit reset");
  AST_FILL_CAUSE: assert property (evq_filled |-> $past(reset_evt | notice_evt) || |wr_d)
    else $error("fill without cause");
endmodule
bind scsi_host_queues scsi_host_queues_props props_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .reset_evt(reset_evt), .notice_evt(notice_evt), .task_abort(task_abort),
  .unit_reset(unit_reset), .ctl_done(ctl_done), .evq_filled(evq_filled));
`default_nettype wire

// ==== test/apb_driver_model.sv ====
// Purpose: driver side register access
// Assumes: apb master, waits on pready
// Notes:   data inverted after release
`timescale 1ns/10ps
`default_nettype none
module apb_driver_model (
  input wire logic        pclk,
  output logic            psel = 0,
  output logic            penable = 0,
  output logic            pwrite = 0,
  output logic     [7:0]  paddr = 0,
  output logic     [31:0] pwdata = 0,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr
);
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Purpose: self-checking bench of the queue engine
// Assumes: unit 1 is target 0 lun 0
// Notes:   expectations from codes in defs
`timescale 1ns/10ps
`include "scsi_host_defs.svh"
`default_nettype none
`define CHK(a,b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb;
  logic pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr, e;
  logic cmd_start = 0, reset_evt = 0, notice_evt = 0, task_abort, unit_reset, ctl_done, evq_filled;
  logic [7:0]  paddr;
  logic [1:0]  rsn = 0;
  logic [31:0] pwdata, prdata, r, m, nmask = 0;
  logic [63:0] tg = 0, ev_unit = 64'h1, abort_tag, urst_addr;
  logic [31:0] sn [3] = '{32'h52500, 32'h62900, 32'h63f0e};
  int fail_count = 0, n_compared = 0, n_fill = 0, n_abort = 0, n_urst = 0;
  scsi_host_queues scsi_host_queues_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cmd_start, .cmd_start_tag(tg), .cmd_start_unit(ev_unit),
    .cmd_end(1'b0), .cmd_end_tag(tg), .reset_evt, .reset_evt_reason(rsn), .reset_evt_unit(ev_unit),
    .notice_evt, .notice_evt_unit(ev_unit), .notice_evt_mask(nmask), .task_abort,
    .task_abort_tag(abort_tag), .unit_reset, .unit_reset_addr(urst_addr), .ctl_done, .evq_filled);
  apb_driver_model apb_driver_model_i (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr);
  initial forever #50 pclk = ~pclk;
  always @(posedge pclk) begin
    n_fill += (evq_filled === 1'b1);
    n_abort += (task_abort === 1'b1);
    n_urst += (unit_reset === 1'b1);
  end
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb_driver_model_i.xfer(1'b1, a, d, r, e);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb_driver_model_i.xfer(1'b0, a, 32'h0, r, e);
    `CHK(r, x)
  endtask
  task ctl(input logic [31:0] t, s, input logic [63:0] u, input logic [31:0] q,
           input logic [7:0] xr, input logic [31:0] xa);
    wr(`A_CTL_TYPE, t);
    wr(`A_CTL_SUBTYPE, s);
    wr(`A_CTL_LUN_LO, u[31:0]);
    wr(`A_CTL_LUN_HI, u[63:32]);
    wr(`A_CTL_TAG_LO, tg[31:0]);
    wr(`A_CTL_TAG_HI, tg[63:32]);
    wr(`A_CTL_EVT_REQ, q);
    wr(`A_CTL_SUBMIT, 32'h0);
    apb_driver_model_i.xfer(1'b0, `A_CTL_SUBMIT, 32'h0, r, e);
    `CHK({r[1], ctl_done}, 2'b11)
    rd(`A_CTL_RESP, {24'h0, xr});
    if (t != 0 && xr == 0) rd(`A_CTL_EVT_ACT, xa);
  endtask
  task ev(input logic n, input logic [1:0] rs, input logic [31:0] k);
    @(posedge pclk);
    if (n) notice_evt <= 1;
    else reset_evt <= 1;
    rsn <= rs;
    nmask <= k;
    @(posedge pclk);
    reset_evt <= 0;
    notice_evt <= 0;
    repeat (2) @(posedge pclk);
  endtask
  task slot(input logic [31:0] w, input logic [31:0] rs, input logic full);
    rd(`A_EVQ_WORD, w);
    if (full) rd(`A_EVQ_LUN_LO, ev_unit[31:0]);
    if (full) rd(`A_EVQ_REASON, rs);
    wr(`A_EVQ_STATUS, 32'h1);
  endtask
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #2_000_000;
    fail_count++;
    wrap_up;
  end
  initial begin
    void'($urandom(32'ha1f98dfe));
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    cmd_start <= 1;
    tg <= {$urandom, $urandom};
    @(posedge pclk);
    cmd_start <= 0;
    ctl(`T_TMF, `TMF_QUERY_TASK, 64'h1, 0, `RESP_FN_OK, 0);
    ctl(`T_TMF, `TMF_ABORT_TASK, 64'h1, 0, `RESP_FN_DONE, 0);
    `CHK({n_abort, abort_tag}, {32'h1, tg})
    ctl(`T_TMF, `TMF_NEXUS_RST, 64'h0940_0001, 0, `RESP_FN_DONE, 0);
    ctl(`T_TMF, `TMF_CLEAR_ACA, 64'h1, 0, `RESP_FN_REJ, 0);
    ctl(`T_TMF, `TMF_UNIT_RST, 64'h1, 0, `RESP_FN_DONE, 0);
    `CHK({n_urst, urst_addr}, {32'h1, 64'h1})
    ctl(`T_TMF, 32'h8, 64'h1, 0, `RESP_FAILURE, 0);
    ctl(32'h3, 0, 64'h1, 0, `RESP_FAILURE, 0);
    ctl(`T_AN_QUERY, 0, 64'h0501, 0, `RESP_BAD_TGT, 0);
    ctl(`T_AN_QUERY, 0, 64'h0940_0001, 0, `RESP_WRONG_UNIT, 0);
    m = $urandom & 32'h7e;
    ctl(`T_AN_QUERY, 0, 64'h1, m, `RESP_OK, m & `EV_SUPPORTED);
    ctl(`T_AN_SUBSCRIBE, 0, 64'h1, 32'h16, `RESP_OK, 32'h14);
    rd(8'h48, 32'h0);
    `CHK(e, 1'b1)
    wr(`A_EVQ_POST, `EVT_INFO_SIZE);
    ev(0, `RSN_REMOVED, 0);
    `CHK(n_fill, 0)
    wr(`A_FEATURES, 32'h2);
    for (int i = 0; i < 3; i++) begin
      if (i > 0) wr(`A_EVQ_POST, `EVT_INFO_SIZE);
      if (i > 0) ev(0, i[1:0], 0);
      else ev(0, `RSN_REMOVED, 0);
      rd(`A_SENSE, sn[i]);
      slot(`EVW_XPORT_RST, i, 1);
    end
    ev(0, `RSN_HARD, 0);
    wr(`A_EVQ_POST, `EVT_INFO_SIZE);
    slot(32'h8000_0000, 0, 0);
    rd(`A_SENSE, sn[1]);
    wr(`A_EVQ_POST, 32'h8);
    slot(`EVW_NONE, 0, 0);
    wr(`A_EVQ_POST, `EVT_INFO_SIZE);
    ev(1, 0, 32'h30);
    slot(`EVW_ASYNC, 32'h10, 1);
    `CHK(n_fill, 6)
    wrap_up;
  end
endmodule
`default_nettype wire
